// [design/dmc_pkg.sv]
// Overview of operation
// R1 - keep moving at least hysteresis past edge
// R2 - halt stops axis, target reached at zero
// R3 - halt release resumes clearing, target cleared
// R4 - power-up handshake answered with status codes
// R5 - controller selects clearing with mode minus two
// R6 - clearing start reports active, then reached
// R7 - bit 4 held, drop interrupts clearing
// R8 - mode bits accepted only when operation enabled; the device also takes bit 6 and the profile field in any state
// R9 - mode changed only under switched-on word; the controller also takes it under the disable word
// R10 - mode minus three selects gear slave
// R11 - gear bit starts follow, zero stops ramped
// R12 - correction bit starts master/slave correction
// R13 - gear halt stops, release restarts gear
// R14 - phasing bit starts or aborts phasing
// R15 - phasing profile equals field plus one
package dmc_pkg;
  localparam logic [15:0] CW_DISABLE   = 16'h0000;
  localparam logic [15:0] CW_SHUTDOWN  = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_ENABLE    = 16'h000f;
  localparam logic [15:0] CW_CLEAR     = 16'h001f;
  localparam logic [15:0] MODE_CLEAR   = 16'hfffe;
  localparam logic [15:0] MODE_GEAR    = 16'hfffd;
  localparam logic [15:0] SW_DISABLED  = 16'h0050;
  localparam logic [15:0] SW_READY     = 16'h0031;
  localparam logic [15:0] SW_SWITCHED  = 16'h0033;
  localparam logic [15:0] SW_ENABLED   = 16'h0037;
  localparam logic [15:0] SW_CLEARING  = 16'h02b7;
  localparam logic [15:0] SW_REACHED   = 16'h0637;
  localparam int BIT_START   = 4;
  localparam int BIT_CORR    = 5;
  localparam int BIT_DSYNC   = 6;
  localparam int BIT_HALT    = 8;
  localparam int BIT_PHASE   = 9;
  localparam int BIT_PROF_LO = 12;
  localparam int BIT_REACHED = 10;
  localparam logic [3:0] LOW_ENABLED = 4'hf;
  localparam logic [15:0] HYST_DEFAULT = 16'h0010;
  localparam logic [15:0] SPEED_MAX    = 16'h0008;
  localparam int APB_CTRL   = 0;
  localparam int APB_MODE   = 4;
  localparam int APB_STATUS = 8;
  localparam int APB_IRQ_ST = 12;
  localparam int APB_IRQ_MK = 16;
endpackage

// [design/dmc_if.sv]
`timescale 1ns/1ps
interface dmc_if;
  logic [15:0] control_word;
  logic [15:0] mode_value_process_word;
  logic [15:0] status_word;
  logic [15:0] mode_display;
  modport device (input control_word, input mode_value_process_word, output status_word, output mode_display);
  modport plc    (output control_word, output mode_value_process_word, input status_word, input mode_display);
endinterface

// [design/dmc_device.sv]
`timescale 1ns/1ps
module dmc_device
  import dmc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  dmc_if.device            bus,
  input  wire logic        i_limit_active,
  input  wire logic [15:0] i_hysteresis,
  output logic             o_drive_enable,
  output logic signed [15:0] o_speed,
  output logic             o_correction_run,
  output logic             o_phasing_run,
  output logic [2:0]       o_phasing_profile,
  output logic             o_direct_sync_disable_bit
);
  typedef enum logic [2:0] {ST_DISABLED, ST_READY, ST_SWITCHED, ST_ENABLED} dmc_pwr_t;
  typedef struct packed {
    dmc_pwr_t    pwr;
    logic [15:0] status;
    logic [15:0] mode;
    logic signed [15:0] speed;
    logic [15:0] hyst_left;
    logic        past_edge;
    logic        clearing;
    logic        corr;
    logic        phase;
    logic [2:0]  prof;
    logic        dsync;
    logic        drive_en;
  } dmc_dev_t;
  dmc_dev_t st, nx;
  logic [15:0] cw;
  logic        enabled_cmd;
  logic        halt, start;

  function automatic logic signed [15:0] ramp(input logic signed [15:0] v, input logic go);
    if (go && v < $signed(SPEED_MAX)) return v + 16'sd1;
    if (!go && v > 16'sd0) return v - 16'sd1;
    return v;
  endfunction

  always_comb begin
    nx = st;
    cw = bus.control_word;
    enabled_cmd = (cw[3:0] == LOW_ENABLED);
    halt  = cw[BIT_HALT];
    start = cw[BIT_START];
    unique case (st.pwr)
      ST_DISABLED: if (cw == CW_SHUTDOWN) nx.pwr = ST_READY;                    // [R4]
      ST_READY:    if (cw == CW_SWITCH_ON) nx.pwr = ST_SWITCHED;               // [R4]
                   else if (cw != CW_SHUTDOWN) nx.pwr = ST_DISABLED;
      ST_SWITCHED: if (cw[3:0] == LOW_ENABLED) nx.pwr = ST_ENABLED;             // [R4]
                   else if (cw != CW_SWITCH_ON) nx.pwr = ST_DISABLED;
      ST_ENABLED:  if (!enabled_cmd) nx.pwr = (cw == CW_SWITCH_ON) ? ST_SWITCHED : ST_DISABLED;
    endcase
    // enable kept as a flop so the output never glitches on decode
    nx.drive_en = (nx.pwr == ST_ENABLED);
    // mode latched only outside operation, a running mode never flips
    if (st.pwr != ST_ENABLED) nx.mode = bus.mode_value_process_word;           // [R9]
    nx.corr = 1'b0;
    nx.phase = 1'b0;
    nx.prof = {1'b0, cw[BIT_PROF_LO+1 -: 2]} + 3'd1;                           // [R15]
    nx.dsync = cw[BIT_DSYNC];
    nx.speed = ramp(st.speed, 1'b0);
    nx.status = SW_DISABLED;
    unique case (st.pwr)
      ST_DISABLED: nx.status = SW_DISABLED;
      ST_READY:    nx.status = SW_READY;                                        // [R4]
      ST_SWITCHED: nx.status = SW_SWITCHED;                                     // [R4]
      ST_ENABLED:  nx.status = SW_ENABLED;                                      // [R4]
    endcase
    if (st.pwr != ST_ENABLED || !enabled_cmd) begin                            // [R8]
      nx.clearing = 1'b0;
      nx.past_edge = 1'b0;
    end else if (st.mode == MODE_CLEAR) begin
      if (!start) begin
        nx.clearing = 1'b0;                                                     // [R7]
        nx.past_edge = 1'b0;
      end else begin
        if (!st.clearing) begin
          nx.clearing = 1'b1;                                                   // [R6]
          nx.hyst_left = i_hysteresis;
          nx.past_edge = 1'b0;
        end
        if (st.clearing && !i_limit_active && !st.past_edge) nx.past_edge = 1'b1;
        if (st.past_edge && st.hyst_left != 16'h0 && st.speed != 16'sd0)
          nx.hyst_left = st.hyst_left - 16'h1;                                  // [R1]
        nx.speed = ramp(st.speed, !halt && !(st.past_edge && st.hyst_left == 16'h0)); // [R1] [R2] [R3]
        if (halt)
          nx.status = (st.speed == 16'sd0) ? SW_REACHED : SW_CLEARING;          // [R2]
        else if (st.past_edge && st.hyst_left == 16'h0 && st.speed == 16'sd0)
          nx.status = SW_REACHED;                                               // [R6]
        else
          nx.status = SW_CLEARING;                                              // [R3] [R6]
      end
    end else if (st.mode == MODE_GEAR) begin                                    // [R10]
      nx.speed = ramp(st.speed, start && !halt);                                // [R11] [R13]
      nx.corr  = cw[BIT_CORR];                                                  // [R12]
      nx.phase = cw[BIT_PHASE];                                                 // [R14]
      if (halt && st.speed == 16'sd0) nx.status = SW_ENABLED | 16'(1 << BIT_REACHED); // [R13]
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '{pwr: ST_DISABLED, status: SW_DISABLED, mode: 16'h0, speed: 16'sd0, hyst_left: 16'h0,
              past_edge: 1'b0, clearing: 1'b0, corr: 1'b0, phase: 1'b0, prof: 3'd1, dsync: 1'b0,
              drive_en: 1'b0};
    end else begin
      st <= nx;
    end
  end

  assign bus.status_word = st.status;
  assign bus.mode_display = st.mode;
  assign o_drive_enable = st.drive_en;
  assign o_speed = st.speed;
  assign o_correction_run = st.corr;
  assign o_phasing_run = st.phase;
  assign o_phasing_profile = st.prof;
  assign o_direct_sync_disable_bit = st.dsync;
endmodule // dmc_device

// [design/dmc_plc.sv]
`timescale 1ns/1ps
module dmc_plc
  import dmc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  dmc_if.plc               bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             o_irq
);
  typedef struct packed {
    logic [15:0] cw;
    logic [15:0] mode;
    logic [15:0] last_status;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mk;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
    logic        irq;
  } dmc_plc_t;
  dmc_plc_t st, nx;
  logic wr, rd;
  logic [1:0] ev;

  always_comb begin
    nx = st;
    // a write lands on the edge that completes the access, never on a wait state
    wr = psel && penable && pwrite && st.rdy;
    rd = psel && !penable;
    nx.rdy = psel && penable && !st.rdy;
    nx.err = 1'b0;
    nx.last_status = bus.status_word;
    ev[0] = (bus.status_word == SW_SWITCHED) && (st.last_status != SW_SWITCHED);
    ev[1] = bus.status_word[BIT_REACHED] && !st.last_status[BIT_REACHED];
    if (wr) begin
      unique case (paddr[7:0])
        8'(APB_CTRL):   nx.cw = pwdata[15:0];                                  // [R4] [R7]
        // mode takes effect only under the switched-on or disable word
        8'(APB_MODE):   if (st.cw == CW_SWITCH_ON || st.cw == CW_DISABLE) nx.mode = pwdata[15:0]; // [R5] [R9]
        8'(APB_IRQ_ST): nx.irq_st = st.irq_st & ~pwdata[1:0];
        8'(APB_IRQ_MK): nx.irq_mk = pwdata[1:0];
        default:        ;
      endcase
    end
    nx.irq_st = nx.irq_st | ev;
    if (rd) begin
      unique case (paddr[7:0])
        8'(APB_CTRL):   nx.rdata = {16'h0, st.cw};
        8'(APB_MODE):   nx.rdata = {16'h0, st.mode};
        8'(APB_STATUS): nx.rdata = {bus.mode_display, bus.status_word};
        8'(APB_IRQ_ST): nx.rdata = {30'h0, st.irq_st};
        8'(APB_IRQ_MK): nx.rdata = {30'h0, st.irq_mk};
        default:        nx.rdata = 32'h0;
      endcase
    end
    // judged one edge early so the error rides with pready; status is read only
    if (psel && penable && !st.rdy)
      nx.err = !(paddr[7:0] inside {8'(APB_CTRL), 8'(APB_MODE), 8'(APB_IRQ_ST), 8'(APB_IRQ_MK)})
               && !(!pwrite && paddr[7:0] == 8'(APB_STATUS));
    nx.irq = |(nx.irq_st & st.irq_mk);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '{cw: CW_DISABLE, mode: 16'h0, last_status: SW_DISABLED, irq_st: 2'h0, irq_mk: 2'h0,
              rdata: 32'h0, rdy: 1'b0, err: 1'b0, irq: 1'b0};
    end else begin
      st <= nx;
    end
  end

  assign bus.control_word = st.cw;
  assign bus.mode_value_process_word = st.mode;
  assign prdata = st.rdata;
  assign pready = st.rdy;
  assign pslverr = st.err;
  assign o_irq = st.irq;
endmodule // dmc_plc

// [verif/dmc_chk.sv]
`timescale 1ns/1ps
module dmc_chk
  import dmc_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [15:0] control_word,
  input wire logic [15:0] mode_value_process_word,
  input wire logic [15:0] status_word,
  input wire logic [15:0] mode_display
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic       ena;
  logic [3:0] low;
  assign ena = (status_word & 16'h0037) == 16'h0037;
  assign low = control_word[3:0];
  AST_RST_STATE: assert property ($fell(i_rst) |-> status_word == SW_DISABLED)
    else $error("status not disabled after reset");
  AST_READY: assert property (status_word == SW_DISABLED && control_word == CW_SHUTDOWN
    |-> ##[1:3] status_word == SW_READY)
    else $error("no ready answer");
  AST_SWITCHED: assert property (status_word == SW_READY && control_word == CW_SWITCH_ON
    |-> ##[1:3] status_word == SW_SWITCHED)
    else $error("no switched-on answer");
  AST_ENABLED: assert property (status_word == SW_SWITCHED && low == LOW_ENABLED |-> ##[1:3] ena)
    else $error("no enabled answer");
  AST_NO_MOTION: assert property ((low != LOW_ENABLED) [*4] |-> !ena)
    else $error("enabled without enable word");
  AST_CLR_START: assert property (mode_value_process_word == MODE_CLEAR && control_word == CW_CLEAR
    && status_word == SW_ENABLED |-> ##[1:3] (status_word == SW_CLEARING || status_word == SW_REACHED))
    else $error("clearing not reported");
  AST_BIT4_DROP: assert property (status_word == SW_CLEARING && !control_word[BIT_START]
    |-> ##[1:3] status_word != SW_CLEARING)
    else $error("clearing not interrupted");
  AST_HALT_STOP: assert property (status_word == SW_CLEARING && control_word[BIT_HALT]
    |-> ##[1:24] status_word == SW_REACHED)
    else $error("halt did not stop clearing");
  AST_HALT_RES: assert property ($fell(control_word[BIT_HALT]) && control_word[BIT_START]
    && low == LOW_ENABLED && mode_value_process_word == MODE_CLEAR && status_word == SW_REACHED
    |-> ##[1:3] !status_word[BIT_REACHED])
    else $error("clearing not resumed");
  AST_GEAR_HALT: assert property (mode_value_process_word == MODE_GEAR && ena && control_word[BIT_HALT]
    && low == LOW_ENABLED |-> ##[1:24] status_word[BIT_REACHED])
    else $error("gear halt did not stop");
  // status lags the state by one edge, so an enabled status means the mode was already frozen
  AST_MODE_HOLD: assert property (ena |-> $stable(mode_display))
    else $error("mode changed while enabled");
  cover property (status_word == SW_CLEARING);
  cover property ($fell(control_word[BIT_HALT]) && status_word == SW_REACHED);
  cover property (mode_value_process_word == MODE_GEAR && status_word[BIT_REACHED]);
endmodule // dmc_chk

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dmc_pkg::*;
  logic               i_clock = 1'b0, i_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, limit_active = 1'b0;
  logic [31:0]        paddr = '0, pwdata = '0, prdata, rdata;
  logic               pready, pslverr, o_irq, serr, irq_a, drv_en, corr_run, ph_run, dsync;
  logic signed [15:0] speed;
  logic [2:0]         prof;
  int                 fails = 0, check_count = 0, cyc = 0, k;
  dmc_if u_dmc_if();
  dmc_device u_dmc_device(.i_clock(i_clock), .i_rst(i_rst), .bus(u_dmc_if), .i_limit_active(limit_active),
    .i_hysteresis(16'h0004), .o_drive_enable(drv_en), .o_speed(speed), .o_correction_run(corr_run),
    .o_phasing_run(ph_run), .o_phasing_profile(prof), .o_direct_sync_disable_bit(dsync));
  dmc_plc u_dmc_plc(.i_clock(i_clock), .i_rst(i_rst), .bus(u_dmc_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_irq(o_irq));
  dmc_chk u_dmc_chk(.i_clock(i_clock), .i_rst(i_rst), .control_word(u_dmc_if.control_word),
    .mode_value_process_word(u_dmc_if.mode_value_process_word), .status_word(u_dmc_if.status_word),
    .mode_display(u_dmc_if.mode_display));
  always #4 i_clock = ~i_clock;
  // a hang anywhere ends here, counted as a mismatch
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // idle edge first so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_clock);
  endtask
  task automatic wait_st(input logic [15:0] exp);
    k = 0;
    do apb(1'b0, APB_STATUS, '0); while (rdata[15:0] !== exp && ++k < 40);
    chk(rdata[15:0], exp);
  endtask
  task automatic wait_mov(input logic mv);
    k = 0;
    do @(posedge i_clock); while ((speed != 0) !== mv && ++k < 40);
    chk(speed != 0, mv);
  endtask
  initial begin
    tick(6);
    i_rst <= 1'b0;
    wait_st(SW_DISABLED);
    wr(32'h20, 32'h1);
    chk(serr, 1'b1);
    apb(1'b0, 32'h20, '0);
    chk(rdata, 32'h0);
    wr(APB_MODE, MODE_CLEAR);
    wr(APB_CTRL, CW_SHUTDOWN);
    wait_st(SW_READY);
    wr(APB_CTRL, CW_SWITCH_ON);
    wait_st(SW_SWITCHED);
    apb(1'b0, APB_IRQ_ST, '0);
    chk(rdata[0], 1'b1);
    wr(APB_IRQ_MK, 32'h0);
    tick(2);
    irq_a = o_irq;
    wr(APB_IRQ_MK, 32'h3);
    tick(2);
    chk({irq_a, o_irq}, 2'b01);
    wr(APB_IRQ_ST, 32'h3);
    tick(2);
    chk(o_irq, 1'b0);
    wr(APB_CTRL, CW_ENABLE);
    wait_st(SW_ENABLED);
    limit_active <= 1'b1;
    wr(APB_CTRL, CW_CLEAR);
    wait_st(SW_CLEARING);
    wait_mov(1'b1);
    wr(APB_CTRL, CW_ENABLE);
    wait_mov(1'b0);
    wr(APB_CTRL, CW_CLEAR);
    wait_st(SW_CLEARING);
    wr(APB_CTRL, 32'h011f);
    wait_st(SW_REACHED);
    chk(drv_en, 1'b1);
    wr(APB_CTRL, CW_CLEAR);
    wait_st(SW_CLEARING);
    wait_mov(1'b1);
    limit_active <= 1'b0;
    k = 0;
    do begin @(posedge i_clock); k++; end while (speed != 0 && k < 100);
    // speed is ramped up, capped at SPEED_MAX, through four hysteresis cycles, so the stop takes more than twice that
    chk(k > 8, 1'b1);
    wait_st(SW_REACHED);
    wr(APB_CTRL, CW_SWITCH_ON);
    wait_st(SW_SWITCHED);
    wr(APB_MODE, MODE_GEAR);
    wr(APB_CTRL, 32'h0017);
    tick(10);
    chk(speed, 32'h0);
    chk(drv_en, 1'b0);
    // a gear word without the enable nibble sends the device back to disabled, so walk it up again
    wr(APB_CTRL, CW_SHUTDOWN);
    wait_st(SW_READY);
    wr(APB_CTRL, CW_SWITCH_ON);
    wait_st(SW_SWITCHED);
    chk(rdata[31:16], MODE_GEAR);
    wr(APB_CTRL, 32'h001f);
    wait_mov(1'b1);
    chk(corr_run, 1'b0);
    wr(APB_CTRL, CW_ENABLE);
    wait_mov(1'b0);
    wr(APB_CTRL, 32'h003f);
    tick(3);
    chk(corr_run, 1'b1);
    wr(APB_CTRL, 32'h011f);
    wait_st(SW_ENABLED | (16'h1 << BIT_REACHED));
    chk(drv_en, 1'b1);
    wr(APB_CTRL, 32'h005f);
    wait_mov(1'b1);
    chk(dsync, 1'b1);
    for (int p = 0; p < 4; p++) begin
      wr(APB_CTRL, 32'h020f | (p << 12));
      tick(3);
      chk(ph_run, 1'b1);
      chk(prof, p + 1);
    end
    wr(APB_CTRL, CW_ENABLE);
    tick(3);
    chk(ph_run, 1'b0);
    wr(APB_MODE, MODE_CLEAR);
    apb(1'b0, APB_MODE, '0);
    chk(rdata[15:0], MODE_GEAR);
    end_of_test();
  end
endmodule // tb_top
